/* logic/bcr_cfg.svh */
/*
  Register offsets, field positions, reset values and the address step of the
  barometer control register bank.
  Assumes it is included by its bare name, once or more, before use.
*/
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH

// Register offsets
`define BCR_A_INT_CFG   8'h0B
`define BCR_A_THS_L     8'h0C
`define BCR_A_THS_H     8'h0D
`define BCR_A_CTRL1     8'h10
`define BCR_A_CTRL2     8'h11
`define BCR_A_CTRL3     8'h12
`define BCR_A_QCTL      8'h14
`define BCR_A_REF_L     8'h15
`define BCR_A_REF_M     8'h16
`define BCR_A_REF_H     8'h17
`define BCR_A_OFS_L     8'h18
`define BCR_A_OFS_H     8'h19
`define BCR_A_LPCFG     8'h1A

// control_two fields
`define BCR_B_TRIM      7
`define BCR_B_QEN       6
`define BCR_B_STOPWM    5
`define BCR_B_AINC      4
`define BCR_B_I2CDIS    3
`define BCR_B_SWRST     2
`define BCR_B_C2RSV     1
`define BCR_B_ONESHOT   0

// interrupt_pin_control fields
`define BCR_B_POL       7
`define BCR_B_DRV       6
`define BCR_B_FULL      5
`define BCR_B_WM        4
`define BCR_B_OVR       3
`define BCR_B_NEW       2
`define BCR_B_SRC       0

// control_one, interrupt config, queue control, low-power fields
`define BCR_B_RATE      4
`define BCR_B_AREF      7
`define BCR_B_AZERO     5
`define BCR_B_THR       3
`define BCR_B_QMODE     5
`define BCR_B_LC        0
`define BCR_B_LPRSV     1

// Reset values
`define BCR_RST_ZERO    8'h00
`define BCR_RST_CTRL2   8'h10

// Address step after each byte when auto-increment is on
`define BCR_ADDR_STEP   8'h01

`endif

/* logic/bcr_pkg.sv */
/*
  Types shared by both ends of the barometer control register bank.
  Assumes bcr_cfg.svh holds the numeric constants.
*/
package bcr_pkg;

  // Queue operating modes
  typedef enum logic [2:0] {
    BCR_Q_BYPASS   = 3'h0,
    BCR_Q_QUEUE    = 3'h1,
    BCR_Q_STREAM   = 3'h2,
    BCR_Q_STR2Q    = 3'h3,
    BCR_Q_BYP2STR  = 3'h4,
    BCR_Q_RESERVED = 3'h5,
    BCR_Q_DYNSTR   = 3'h6,
    BCR_Q_BYP2Q    = 3'h7
  } bcr_qmode_t;

  // Interrupt pin content selection
  typedef enum logic [1:0] {
    BCR_S_DATA  = 2'h0,
    BCR_S_PHIGH = 2'h1,
    BCR_S_PLOW  = 2'h2,
    BCR_S_PBOTH = 2'h3
  } bcr_isrc_t;

  // Trim reload sequencer
  typedef enum logic [2:0] {
    BCR_T_IDLE = 3'b001,
    BCR_T_WAIT = 3'b010,
    BCR_T_COPY = 3'b100
  } bcr_trim_st_t;

endpackage : bcr_pkg

/* logic/bcr_if.sv */
/*
  Link between the host controller and the barometer register bank:
  byte register access plus the interrupt pin.
  Assumes both ends share ref_clk; the pin level is resolved here.
*/
`timescale 1ns/1ps
`default_nettype none

interface bcr_if #(
  parameter logic PULL_LEVEL = 1'b1
);
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic       acc_wr;
  logic       acc_rd;
  logic       acc_seq;
  logic [7:0] acc_rdata;
  logic       int_out;
  logic       int_oe;
  wire        int_level;

  // Undriven pin falls to the external pull level
  assign int_level = int_oe ? int_out : PULL_LEVEL;

  modport device (
    input  acc_addr, acc_wdata, acc_wr, acc_rd, acc_seq,
    output acc_rdata, int_out, int_oe
  );

  modport host (
    output acc_addr, acc_wdata, acc_wr, acc_rd, acc_seq,
    input  acc_rdata, int_level
  );
endinterface : bcr_if

`default_nettype wire

/* logic/bcr_device.sv */
/*
  Device end: control and configuration registers of the barometer, trim
  reload sequencing, conversion triggering, offset subtraction and the
  interrupt pin driver.
  Assumes core inputs (sample tick, results, queue and threshold flags)
  come from logic on ref_clk, and the host obeys its own write limits.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcr_cfg.svh"

module bcr_device (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  bcr_if.device                  link,
  input  wire logic              odr_tick,
  input  wire logic              meas_valid,
  input  wire logic [23:0]       meas_pressure,
  input  wire logic              trim_done,
  input  wire logic              newdata_signal,
  input  wire logic              queue_overrun,
  input  wire logic              queue_watermark_hit,
  input  wire logic              queue_full,
  input  wire logic              press_high,
  input  wire logic              press_low,
  output logic                   trim_copy,
  output logic                   conv_start,
  output logic [23:0]            pressure_result,
  output logic                   result_update,
  output logic                   serial2w_disable,
  output logic                   queue_enable,
  output logic                   stop_at_watermark,
  output bcr_pkg::bcr_qmode_t    queue_mode_sel,
  output logic [4:0]             queue_watermark,
  output logic                   low_current_sel
);
  import bcr_pkg::*;

  logic [7:0]   icfg_reg, icfg_next, thl_reg, thl_next, thh_reg, thh_next;
  logic [7:0]   c1_reg, c1_next, c2_reg, c2_next, c3_reg, c3_next;
  logic [7:0]   qc_reg, qc_next, rl_reg, rl_next, rm_reg, rm_next;
  logic [7:0]   rh_reg, rh_next, ol_reg, ol_next, oh_reg, oh_next;
  logic [7:0]   lp_reg, lp_next, ptr_reg, ptr_next, rdata_reg, rdata_next;
  bcr_trim_st_t trim_reg, trim_next;
  logic         copy_reg, copy_next, conv_reg, conv_next;
  logic         upd_reg, upd_next, iout_reg, iout_next, ioe_reg, ioe_next;
  logic [23:0]  pres_reg, pres_next;
  logic [7:0]   eff_addr;
  logic         powered_down, act, lvl;
  logic [23:0]  ref_p, ofs_p;

  assign eff_addr     = link.acc_seq ? ptr_reg : link.acc_addr;
  assign powered_down = (c1_reg[`BCR_B_RATE +: 3] == 3'h0);
  assign ref_p        = {rh_reg, rm_reg, rl_reg};
  assign ofs_p        = {oh_reg, ol_reg, 8'h00};

  //////////////////////////////////////////////////////////////////////////
  // Register file, trim sequencer and conversion control
  always_comb begin
    icfg_next = icfg_reg; thl_next = thl_reg; thh_next = thh_reg;
    c1_next = c1_reg; c2_next = c2_reg; c3_next = c3_reg;
    qc_next = qc_reg; rl_next = rl_reg; rm_next = rm_reg; rh_next = rh_reg;
    ol_next = ol_reg; oh_next = oh_reg; lp_next = lp_reg;
    ptr_next = ptr_reg; rdata_next = 8'h00;
    trim_next = trim_reg; copy_next = 1'b0; conv_next = 1'b0;
    upd_next = 1'b0; pres_next = pres_reg;
    // Soft reset is acted on the cycle after the write, then clears
    if (c2_reg[`BCR_B_SWRST]) begin
      icfg_next = `BCR_RST_ZERO; thl_next = `BCR_RST_ZERO;
      thh_next = `BCR_RST_ZERO; c1_next = `BCR_RST_ZERO;
      c2_next = `BCR_RST_CTRL2; c3_next = `BCR_RST_ZERO;
      qc_next = `BCR_RST_ZERO; rl_next = `BCR_RST_ZERO;
      rm_next = `BCR_RST_ZERO; rh_next = `BCR_RST_ZERO;
    end
    // Trim reload waits for the next sample tick before copying
    case (trim_reg)
      BCR_T_IDLE: begin
        if (c2_reg[`BCR_B_TRIM]) trim_next = BCR_T_WAIT;
      end
      BCR_T_WAIT: begin
        if (!c2_reg[`BCR_B_TRIM]) trim_next = BCR_T_IDLE;
        else if (odr_tick) begin
          trim_next = BCR_T_COPY;
          copy_next = 1'b1;
        end
      end
      BCR_T_COPY: begin
        if (trim_done) begin
          trim_next = BCR_T_IDLE;
          c2_next[`BCR_B_TRIM] = 1'b0;
        end
      end
      default: trim_next = BCR_T_IDLE;
    endcase
    // Continuous sampling starts a conversion on every tick
    if (!powered_down && odr_tick) conv_next = 1'b1;
    // Results land only when a conversion was asked for
    if (meas_valid && (!powered_down || c2_reg[`BCR_B_ONESHOT])) begin
      upd_next = 1'b1;
      c2_next[`BCR_B_ONESHOT] = 1'b0;
      if (icfg_reg[`BCR_B_AZERO] || icfg_reg[`BCR_B_AREF])
        pres_next = meas_pressure - ref_p;
      else
        pres_next = meas_pressure - ofs_p;
    end
    // Host writes come last so a set beats a same-cycle hardware clear
    if (link.acc_wr) begin
      ptr_next = eff_addr + (c2_reg[`BCR_B_AINC] ? `BCR_ADDR_STEP : 8'h00);
      if (eff_addr == `BCR_A_INT_CFG) icfg_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_THS_L) thl_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_THS_H) thh_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_CTRL1) c1_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_CTRL2) begin
        c2_next = link.acc_wdata;
        // Trigger outside power-down is dropped
        c2_next[`BCR_B_ONESHOT] = link.acc_wdata[`BCR_B_ONESHOT] &&
                                  powered_down;
        conv_next = conv_next || c2_next[`BCR_B_ONESHOT];
        c2_next[`BCR_B_TRIM] = link.acc_wdata[`BCR_B_TRIM] ||
                               c2_next[`BCR_B_TRIM];
      end
      else if (eff_addr == `BCR_A_CTRL3) c3_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_QCTL) qc_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_REF_L) rl_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_REF_M) rm_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_REF_H) rh_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_OFS_L) ol_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_OFS_H) oh_next = link.acc_wdata;
      else if (eff_addr == `BCR_A_LPCFG) lp_next = link.acc_wdata;
    end
    // Read data stands only in the cycle after the strobe
    if (link.acc_rd) begin
      ptr_next = eff_addr + (c2_reg[`BCR_B_AINC] ? `BCR_ADDR_STEP : 8'h00);
      if (eff_addr == `BCR_A_INT_CFG) rdata_next = icfg_reg;
      else if (eff_addr == `BCR_A_THS_L) rdata_next = thl_reg;
      else if (eff_addr == `BCR_A_THS_H) rdata_next = thh_reg;
      else if (eff_addr == `BCR_A_CTRL1) rdata_next = c1_reg;
      else if (eff_addr == `BCR_A_CTRL2) rdata_next = c2_reg;
      else if (eff_addr == `BCR_A_CTRL3) rdata_next = c3_reg;
      else if (eff_addr == `BCR_A_QCTL) rdata_next = qc_reg;
      else if (eff_addr == `BCR_A_REF_L) rdata_next = rl_reg;
      else if (eff_addr == `BCR_A_REF_M) rdata_next = rm_reg;
      else if (eff_addr == `BCR_A_REF_H) rdata_next = rh_reg;
      else if (eff_addr == `BCR_A_OFS_L) rdata_next = ol_reg;
      else if (eff_addr == `BCR_A_OFS_H) rdata_next = oh_reg;
      else if (eff_addr == `BCR_A_LPCFG) rdata_next = lp_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt pin: select, then apply polarity and pad driver style
  always_comb begin
    case (bcr_isrc_t'(c3_reg[`BCR_B_SRC +: 2]))
      // Any enabled data source asserts the pin
      BCR_S_DATA:  act = (c3_reg[`BCR_B_NEW]  && newdata_signal) ||
                         (c3_reg[`BCR_B_WM]   && queue_watermark_hit) ||
                         (c3_reg[`BCR_B_OVR]  && queue_overrun) ||
                         (c3_reg[`BCR_B_FULL] && queue_full);
      BCR_S_PHIGH: act = press_high;
      BCR_S_PLOW:  act = press_low;
      default:     act = press_high || press_low;
    endcase
    lvl       = act ^ c3_reg[`BCR_B_POL];
    iout_next = lvl;
    // Open drain lets go of the pad while idle
    ioe_next  = c3_reg[`BCR_B_DRV] ? act : 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      icfg_reg <= `BCR_RST_ZERO; thl_reg <= `BCR_RST_ZERO;
      thh_reg <= `BCR_RST_ZERO; c1_reg <= `BCR_RST_ZERO;
      c2_reg <= `BCR_RST_CTRL2; c3_reg <= `BCR_RST_ZERO;
      qc_reg <= `BCR_RST_ZERO; rl_reg <= `BCR_RST_ZERO;
      rm_reg <= `BCR_RST_ZERO; rh_reg <= `BCR_RST_ZERO;
      ol_reg <= `BCR_RST_ZERO; oh_reg <= `BCR_RST_ZERO;
      lp_reg <= `BCR_RST_ZERO; ptr_reg <= 8'h00; rdata_reg <= 8'h00;
      trim_reg <= BCR_T_IDLE; copy_reg <= 1'b0; conv_reg <= 1'b0;
      upd_reg <= 1'b0; pres_reg <= 24'h000000;
      iout_reg <= 1'b0; ioe_reg <= 1'b1;
    end else begin
      icfg_reg <= icfg_next; thl_reg <= thl_next; thh_reg <= thh_next;
      c1_reg <= c1_next; c2_reg <= c2_next; c3_reg <= c3_next;
      qc_reg <= qc_next; rl_reg <= rl_next; rm_reg <= rm_next;
      rh_reg <= rh_next; ol_reg <= ol_next; oh_reg <= oh_next;
      lp_reg <= lp_next; ptr_reg <= ptr_next; rdata_reg <= rdata_next;
      trim_reg <= trim_next; copy_reg <= copy_next; conv_reg <= conv_next;
      upd_reg <= upd_next; pres_reg <= pres_next;
      iout_reg <= iout_next; ioe_reg <= ioe_next;
    end
  end

  // Outputs straight from registers
  assign link.acc_rdata    = rdata_reg;
  assign link.int_out      = iout_reg;
  assign link.int_oe       = ioe_reg;
  assign trim_copy         = copy_reg;
  assign conv_start        = conv_reg;
  assign pressure_result   = pres_reg;
  assign result_update     = upd_reg;
  assign serial2w_disable  = c2_reg[`BCR_B_I2CDIS];
  assign queue_enable      = c2_reg[`BCR_B_QEN];
  assign stop_at_watermark = c2_reg[`BCR_B_STOPWM];
  assign queue_mode_sel    =
    bcr_qmode_t'(qc_reg[`BCR_B_QMODE +: 3]);
  assign queue_watermark   = qc_reg[4:0];
  assign low_current_sel   = lp_reg[`BCR_B_LC];

endmodule : bcr_device

`default_nettype wire

/* logic/bcr_host.sv */
/*
  Host end: forwards software register accesses onto the link, keeps the
  device's write limits on plain (non-sequential) writes and watches the interrupt pin.
  Assumes the device answers a read one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcr_cfg.svh"

module bcr_host (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  bcr_if.host              link,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic        cmd_seq,
  output logic [7:0]       cmd_rdata,
  output logic             cmd_rvalid,
  output logic             cmd_refused,
  output logic             irq_active
);
  import bcr_pkg::*;

  logic [7:0] a_reg, a_next, d_reg, d_next, rd_d_reg, rd_d_next;
  logic       wr_reg, wr_next, rd_reg, rd_next, sq_reg, sq_next;
  logic       pend_reg, pend_next, plp_reg, plp_next;
  logic       rv_reg, rv_next, ref_reg, ref_next;
  logic [2:0] rate_reg, rate_next;
  logic       lc_reg, lc_next, rsv_reg, rsv_next, pol_reg, pol_next;
  logic       s1_reg, s2_reg, irq_reg, irq_next;

  //////////////////////////////////////////////////////////////////////////
  // Command forwarding with write fix-ups and shadow tracking
  always_comb begin
    a_next = cmd_addr; d_next = cmd_wdata; sq_next = cmd_seq;
    wr_next = 1'b0; rd_next = cmd_rd; ref_next = 1'b0;
    rate_next = rate_reg; lc_next = lc_reg; rsv_next = rsv_reg;
    pol_next = pol_reg; rd_d_next = 8'h00; rv_next = 1'b0;
    pend_next = rd_reg; plp_next = rd_reg && !sq_reg &&
                                   (a_reg == `BCR_A_LPCFG);
    if (cmd_wr) begin
      wr_next = 1'b1;
      if (!cmd_seq && cmd_addr == `BCR_A_CTRL2)
        d_next[`BCR_B_C2RSV] = 1'b0;
      if (!cmd_seq && cmd_addr == `BCR_A_CTRL1)
        rate_next = cmd_wdata[`BCR_B_RATE +: 3];
      if (!cmd_seq && cmd_addr == `BCR_A_CTRL3)
        pol_next = cmd_wdata[`BCR_B_POL];
      if (!cmd_seq && cmd_addr == `BCR_A_LPCFG) begin
        // Keep reserved bit, pass the low-current bit, zero the rest
        d_next = {6'h00, rsv_reg, cmd_wdata[`BCR_B_LC]};
        if (cmd_wdata[`BCR_B_LC] != lc_reg && rate_reg != 3'h0) begin
          wr_next  = 1'b0;
          ref_next = 1'b1;
        end else lc_next = cmd_wdata[`BCR_B_LC];
      end
    end
    // Capture read data the cycle it stands on the link
    if (pend_reg) begin
      rd_d_next = link.acc_rdata;
      rv_next   = 1'b1;
      if (plp_reg) rsv_next = link.acc_rdata[`BCR_B_LPRSV];
    end
    irq_next = s2_reg ^ pol_reg; // Pin level back to active-high
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers; the pin passes three flops since it comes from the device pad
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      a_reg <= 8'h00; d_reg <= 8'h00; wr_reg <= 1'b0; rd_reg <= 1'b0;
      sq_reg <= 1'b0; pend_reg <= 1'b0; plp_reg <= 1'b0;
      rd_d_reg <= 8'h00; rv_reg <= 1'b0; ref_reg <= 1'b0;
      rate_reg <= 3'h0; lc_reg <= 1'b0; rsv_reg <= 1'b0; pol_reg <= 1'b0;
      s1_reg <= 1'b0; s2_reg <= 1'b0; irq_reg <= 1'b0;
    end else begin
      a_reg <= a_next; d_reg <= d_next; wr_reg <= wr_next;
      rd_reg <= rd_next; sq_reg <= sq_next; pend_reg <= pend_next;
      plp_reg <= plp_next; rd_d_reg <= rd_d_next; rv_reg <= rv_next;
      ref_reg <= ref_next; rate_reg <= rate_next; lc_reg <= lc_next;
      rsv_reg <= rsv_next; pol_reg <= pol_next;
      s1_reg <= link.int_level; s2_reg <= s1_reg; irq_reg <= irq_next;
    end
  end

  assign link.acc_addr  = a_reg;
  assign link.acc_wdata = d_reg;
  assign link.acc_wr    = wr_reg;
  assign link.acc_rd    = rd_reg;
  assign link.acc_seq   = sq_reg;
  assign cmd_rdata      = rd_d_reg;
  assign cmd_rvalid     = rv_reg;
  assign cmd_refused    = ref_reg;
  assign irq_active     = irq_reg;

endmodule : bcr_host

`default_nettype wire

/* tb/bcr_asserts.sv */
/* Checker beside the bcr_if link: read slot, readback, pin drive.
   Assumes it sees the link signals of one host and one device. */
`timescale 1ns/1ps
`default_nettype none
module bcr_asserts (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic       acc_wr,
  input wire logic       acc_rd,
  input wire logic       acc_seq,
  input wire logic [7:0] acc_rdata,
  input wire logic       int_out,
  input wire logic       int_oe
);
  default clocking dck @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  logic [7:0] pin_reg, pin_next;
  logic [1:0] age_reg, age_next;
  logic       ainc_reg, ainc_next;
  logic       plain;
  assign plain = acc_wr && !acc_seq;
  //////////////////////////////////////////////////////////////////////////
  // Shadows; age makes the pin checks wait out register and pad latency
  always_comb begin
    pin_next  = pin_reg;
    ainc_next = ainc_reg;
    age_next  = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    if (acc_wr) age_next = 2'h0;
    if (plain && acc_addr == 8'h12) pin_next = acc_wdata;
    if (plain && acc_addr == 8'h11) ainc_next = acc_wdata[4];
    if (plain && acc_addr == 8'h11 && acc_wdata[2]) begin
      pin_next  = 8'h00;
      ainc_next = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_reg  <= 8'h00;
      age_reg  <= 2'h3;
      ainc_reg <= 1'b1;
    end else begin
      pin_reg  <= pin_next;
      age_reg  <= age_next;
      ainc_reg <= ainc_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_wr;
    plain && acc_addr inside {8'h12, [8'h14:8'h19]};
  endsequence
  sequence s_pair;
    plain && acc_addr inside {[8'h14:8'h18]} ##1 acc_wr && acc_seq;
  endsequence
  sequence s_swrst;
    plain && acc_addr == 8'h11 && acc_wdata[2];
  endsequence
  // Read data stand only in the slot after a read
  AST_RDATA_IDLE: assert property (!acc_rd |=> acc_rdata == 8'h00)
    else $error("read data outside its slot");
  AST_READBACK: assert property (s_wr ##1 acc_rd && !acc_seq &&
    acc_addr == $past(acc_addr) |=> acc_rdata == $past(acc_wdata, 2))
    else $error("register readback differs");
  AST_AUTOINC: assert property (s_pair ##1 acc_rd && !acc_seq &&
    acc_addr == $past(acc_addr, 2) + (ainc_reg ? 8'h01 : 8'h00)
    |=> acc_rdata == $past(acc_wdata, 2))
    else $error("sequential byte landed wrongly");
  AST_SWRST: assert property (s_swrst ##4
    acc_rd && !acc_seq && acc_addr == 8'h11 |=> acc_rdata == 8'h10)
    else $error("soft reset did not restore control_two");
  AST_PP_DRIVE: assert property (age_reg == 2'h3 && !pin_reg[6]
    |-> int_oe) else $error("push-pull pad not driven");
  AST_OD_RELEASE: assert property (age_reg == 2'h3 &&
    pin_reg[6] && pin_reg[5:0] == 6'h00 |-> !int_oe)
    else $error("open-drain pad drives while idle");
  AST_IDLE_LEVEL: assert property (age_reg == 2'h3 &&
    pin_reg[6:0] == 7'h00 |-> int_out == pin_reg[7])
    else $error("idle pin level wrong");
  AST_OD_ACTIVE: assert property (age_reg == 2'h3 &&
    pin_reg[6] && int_oe |-> int_out == !pin_reg[7])
    else $error("open-drain pad drives the idle level");
  AST_RESET_PIN: assert property ($rose(reset_n) |->
    int_oe && !int_out) else $error("pin not idle after reset");
endmodule : bcr_asserts
`default_nettype wire

/* tb/tb_top.sv */
/* Self-checking bench joining host and device ends through bcr_if.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bcr_pkg::*;
  logic        ref_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  cmd_addr = 8'h00, cmd_wdata = 8'h00;
  logic        cmd_wr = 1'b0, cmd_rd = 1'b0, cmd_seq = 1'b0;
  logic        odr_tick = 1'b0, meas_valid = 1'b0, trim_done = 1'b0;
  logic        newdata_signal = 1'b0, queue_overrun = 1'b0;
  logic        queue_watermark_hit = 1'b0, queue_full = 1'b0;
  logic        press_high = 1'b0, press_low = 1'b0;
  logic [23:0] meas_pressure = 24'h0, pressure_result, res_cap;
  logic [7:0]  cmd_rdata, c, mdl [0:255];
  logic        cmd_rvalid, cmd_refused, irq_active, trim_copy, conv_start;
  logic        result_update, serial2w_disable, queue_enable, act;
  logic        stop_at_watermark, low_current_sel;
  logic [4:0]  queue_watermark;
  bcr_qmode_t  queue_mode_sel;
  int mismatches = 0, n_compared = 0, n_conv = 0, n_trim = 0, n_ref = 0;
  int n0, k;
  logic [7:0] al [14] = '{8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12,
    8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h20};
  bcr_if #(.PULL_LEVEL(1'b1)) link ();
  bcr_device bcr_device_i (.ref_clk, .reset_n, .link(link), .odr_tick,
    .meas_valid, .meas_pressure, .trim_done, .newdata_signal,
    .queue_overrun, .queue_watermark_hit, .queue_full, .press_high,
    .press_low, .trim_copy, .conv_start, .pressure_result, .result_update,
    .serial2w_disable, .queue_enable, .stop_at_watermark, .queue_mode_sel,
    .queue_watermark, .low_current_sel);
  bcr_host bcr_host_i (.ref_clk, .reset_n, .link(link), .cmd_addr,
    .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_seq, .cmd_rdata, .cmd_rvalid,
    .cmd_refused, .irq_active);
  bcr_asserts bcr_asserts_i (.ref_clk, .reset_n, .acc_addr(link.acc_addr),
    .acc_wdata(link.acc_wdata), .acc_wr(link.acc_wr), .acc_rd(link.acc_rd),
    .acc_seq(link.acc_seq), .acc_rdata(link.acc_rdata),
    .int_out(link.int_out), .int_oe(link.int_oe));
  always #5 ref_clk = ~ref_clk;
  // Pulse counters let a check see exactly one event, not just some
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) n_conv++;
    if (trim_copy === 1'b1) n_trim++;
    if (cmd_refused === 1'b1) n_ref++;
    if (result_update === 1'b1) res_cap = pressure_result;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [23:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // Bounded wait for the read answer; a lost answer ends the run
  task automatic get(input logic [7:0] ex);
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #1;
      if (cmd_rvalid === 1'b1) break;
    end
    if (i < 8) chk(24'(cmd_rdata), 24'(ex));
    else begin
      mismatches++;
      results();
    end
  endtask : get
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    mdl[a] = d;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    cmd_addr <= a;
    cmd_rd   <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    get(mdl[a]);
  endtask : rd
  // Write, optional sequential byte, then an immediate read back
  task automatic acc(input logic [7:0] a, d, d2, input bit pair);
    logic [7:0] ra;
    ra = a;
    @(posedge ref_clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    mdl[a] = d;
    if (pair) begin
      ra = mdl[8'h11][4] ? a + 8'h01 : a;
      mdl[ra] = d2;
      @(posedge ref_clk);
      cmd_wdata <= d2;
      cmd_seq   <= 1'b1;
    end
    @(posedge ref_clk);
    cmd_wr   <= 1'b0;
    cmd_seq  <= 1'b0;
    cmd_addr <= ra;
    cmd_rd   <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    get(mdl[ra]);
  endtask : acc
  task automatic pulse(input int w);
    @(posedge ref_clk);
    {trim_done, meas_valid, odr_tick} <= 3'(1 << w);
    @(posedge ref_clk);
    {trim_done, meas_valid, odr_tick} <= 3'h0;
  endtask : pulse
  task automatic measure(input logic [23:0] sub);
    // Power-down results land only for a requested conversion
    wr(8'h11, 8'h11);
    mdl[8'h11] = 8'h10;
    meas_pressure <= 24'($urandom);
    pulse(1);
    step(2);
    chk(res_cap, meas_pressure - sub);
  endtask : measure
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0FF9D91C));
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h11] = 8'h10;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr(8'h20, 8'h77);
    mdl[8'h20] = 8'h00;
    foreach (al[i]) rd(al[i]);
    for (k = 0; k < 20; k++) begin
      c = (k % 7 == 0) ? 8'h12 : 8'h14 + 8'($urandom_range(5));
      acc(c, 8'($urandom), 8'h00, 1'b0);
    end
    for (k = 0; k < 8; k++) begin
      c = {3'(k), 5'($urandom)};
      wr(8'h14, c);
      step(2);
      chk(24'(queue_mode_sel), 24'(k));
      chk(24'(queue_watermark), 24'(c[4:0]));
    end
    wr(8'h11, 8'h6A);
    mdl[8'h11] = 8'h68;
    rd(8'h11);
    chk(24'({serial2w_disable, queue_enable, stop_at_watermark}),
      24'h7);
    acc(8'h15, 8'($urandom), 8'($urandom), 1'b1);
    wr(8'h11, 8'h10);
    acc(8'h16, 8'($urandom), 8'($urandom), 1'b1);
    wr(8'h18, 8'($urandom));
    wr(8'h19, 8'($urandom));
    n0 = n_conv;
    wr(8'h11, 8'h11);
    mdl[8'h11] = 8'h10;
    step(4);
    chk(24'(n_conv - n0), 24'h1);
    measure({mdl[8'h19], mdl[8'h18], 8'h00});
    rd(8'h11);
    for (k = 0; k < 2; k++) begin
      wr(8'h15 + 8'(k), 8'($urandom));
      wr(8'h17, 8'($urandom));
      wr(8'h0B, k ? 8'h80 : 8'h20);
      measure({mdl[8'h17], mdl[8'h16], mdl[8'h15]});
    end
    wr(8'h0B, 8'h00);
    n0 = n_trim;
    wr(8'h11, 8'h90);
    step(4);
    chk(24'(n_trim - n0), 24'h0);
    pulse(0);
    step(1);
    chk(24'(n_trim - n0), 24'h1);
    pulse(2);
    step(2);
    mdl[8'h11] = 8'h10;
    rd(8'h11);
    wr(8'h10, 8'h10);
    n0 = n_conv;
    pulse(0);
    step(2);
    chk(24'(n_conv - n0), 24'h1);
    wr(8'h11, 8'h11);
    mdl[8'h11] = 8'h10;
    rd(8'h11);
    n0 = n_ref;
    wr(8'h1A, 8'h01);
    mdl[8'h1A] = 8'h00;
    step(3);
    chk(24'({n_ref - n0, low_current_sel}), 24'h2);
    wr(8'h10, 8'h00);
    wr(8'h1A, 8'hFF);
    mdl[8'h1A] = 8'h01;
    rd(8'h1A);
    chk(24'(low_current_sel), 24'h1);
    wr(8'h1A, 8'h00);
    for (k = 0; k < 24; k++) begin
      c = 8'($urandom);
      c[1:0] = 2'(k);
      c[7] = c[7] | c[6];
      @(posedge ref_clk);
      {newdata_signal, queue_overrun, queue_watermark_hit, queue_full,
        press_high, press_low} <= 6'($urandom);
      wr(8'h12, c);
      step(8);
      case (c[1:0])
        2'h0: act = |({queue_full, queue_watermark_hit, queue_overrun,
          newdata_signal} & c[5:2]);
        2'h1: act = press_high;
        2'h2: act = press_low;
        default: act = press_high | press_low;
      endcase
      chk(24'(irq_active), 24'(act));
      chk(24'(link.int_level), 24'(act ^ c[7]));
    end
    wr(8'h12, 8'hC0);
    step(6);
    wr(8'h12, 8'h80);
    step(6);
    wr(8'h0C, 8'h5A);
    wr(8'h10, 8'h0C);
    wr(8'h11, 8'h04);
    step(2);
    foreach (al[i]) if (al[i] < 8'h18) mdl[al[i]] = 8'h00;
    mdl[8'h11] = 8'h10;
    rd(8'h11);
    foreach (al[i]) rd(al[i]);
    results();
  end
endmodule : tb_top
`default_nettype wire
